//--- tb_two_port_block_ram.sv
`timescale 1ns/1ps

module tb_two_port_block_ram;
    localparam logic [17:0] D = 18'h2a5c3;
    localparam logic [17:0] E = 18'h15a3c;
    logic        clk = 1'b0, nrst = 1'b1, pipe = 1'b0;
    logic        wclk = 1'b0, wfall = 1'b0, wstb = 1'b1, whi = 1'b0;
    logic        rclk = 1'b0, rfall = 1'b0, rstb = 1'b1, rhi = 1'b0;
    logic [1:0]  ww = 2'h1, rw = 2'h1;
    logic [8:0]  rloc = 9'h000, wloc_u = 9'h000, wloc;
    logic [17:0] wdat_u = 18'h00000, wdat, rdat;
    logic        rvalid, wdone, wfault;
    logic [17:0] n_done = 18'h0, n_fault = 18'h0, n_valid = 18'h0;
    int          err_total = 0, checks_done = 0;

    always #12.5 clk = ~clk;

    // count status pulses
    always @(posedge clk) begin
        if (wdone === 1'b1) n_done <= n_done + 18'h1;
        if (wfault === 1'b1) n_fault <= n_fault + 18'h1;
        if (rvalid === 1'b1) n_valid <= n_valid + 18'h1;
    end

    tpr_fabric_user u_user (.wide_in(ww == tpr_pkg::SEL_256X18), .loc_in(wloc_u),
        .data_in(wdat_u), .loc_out(wloc), .data_out(wdat));

    tpr_two_port_ram DUT (.CORE_CLK_IN(clk), .NRST_IN(nrst), .WRITE_CLK_IN(wclk),
        .WRITE_CLK_FALL_IN(wfall), .WRITE_STROBE_IN(wstb), .WRITE_STROBE_HIGH_IN(whi),
        .WRITE_WIDTH_SEL_IN(ww), .WRITE_LOCATION_IN(wloc), .WRITE_DATA_IN(wdat),
        .READ_CLK_IN(rclk), .READ_CLK_FALL_IN(rfall), .READ_STROBE_IN(rstb),
        .READ_STROBE_HIGH_IN(rhi), .READ_WIDTH_SEL_IN(rw), .READ_LOCATION_IN(rloc),
        .PIPE_IN(pipe), .READ_DATA_OUT(rdat), .READ_VALID_OUT(rvalid),
        .WRITE_DONE_OUT(wdone), .WIDTH_FAULT_OUT(wfault));

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one write port clock cycle, inputs held well past the active edge
    task automatic wr(input logic [1:0] w, input logic [8:0] a, input logic [17:0] d,
                      input logic s);
        @(negedge clk);
        ww = w; wloc_u = a; wdat_u = d; wstb = s; wclk = 1'b1;
        repeat (8) @(negedge clk);
        wclk = 1'b0;
        repeat (8) @(negedge clk);
    endtask : wr

    // one read port clock cycle with the strobe active
    task automatic rd(input logic [1:0] w, input logic [8:0] a);
        @(negedge clk);
        rw = w; rloc = a; rstb = rhi; rclk = 1'b1;
        repeat (8) @(negedge clk);
        rclk = 1'b0;
        repeat (8) @(negedge clk);
    endtask : rd

    task automatic t_wide;
        wr(tpr_pkg::SEL_256X18, 9'h005, D, 1'b0);
        chk(n_done, 18'h1);
        rd(tpr_pkg::SEL_256X18, 9'h005);
        chk(rdat, D);
        chk(n_valid, 18'h1);
        rd(tpr_pkg::SEL_512X9, 9'h00a);
        chk({9'h0, rdat[8:0]}, {9'h0, D[8:0]});
        rd(tpr_pkg::SEL_512X9, 9'h00b);
        chk({9'h0, rdat[8:0]}, {9'h0, D[17:9]});
    endtask : t_wide

    task automatic t_narrow;
        wr(tpr_pkg::SEL_512X9, 9'h12c, 18'h3ffa7, 1'b0);
        rd(tpr_pkg::SEL_512X9, 9'h12c);
        chk({9'h0, rdat[8:0]}, 18'h001a7);
        rd(tpr_pkg::SEL_256X18, 9'h096);
        chk({9'h0, rdat[8:0]}, 18'h001a7);
    endtask : t_narrow

    task automatic t_refuse;
        wr(2'h0, 9'h005, E, 1'b0);
        wr(2'h3, 9'h005, E, 1'b0);
        rd(2'h3, 9'h005);
        chk(n_fault, 18'h3);
        chk(n_done, 18'h2);
        rd(tpr_pkg::SEL_256X18, 9'h005);
        chk(rdat, D);
    endtask : t_refuse

    task automatic t_edge;
        wr(tpr_pkg::SEL_256X18, 9'h005, E, 1'b1);
        chk(n_done, 18'h2);
        whi = 1'b1; wfall = 1'b1; rhi = 1'b1; rfall = 1'b1;
        wr(tpr_pkg::SEL_256X18, 9'h105, E, 1'b1);
        chk(n_done, 18'h3);
        rd(tpr_pkg::SEL_256X18, 9'h005);
        chk(rdat, E);
        whi = 1'b0; wfall = 1'b0; rhi = 1'b0; rfall = 1'b0;
    endtask : t_edge

    task automatic t_pipe;
        pipe = 1'b1;
        rd(tpr_pkg::SEL_256X18, 9'h005);
        rd(tpr_pkg::SEL_256X18, 9'h096);
        chk(rdat, E);
        rd(tpr_pkg::SEL_256X18, 9'h005);
        chk({9'h0, rdat[8:0]}, 18'h001a7);
        pipe = 1'b0;
    endtask : t_pipe

    // reset while port clocks idle, away from their edges
    task automatic t_reset;
        @(negedge clk) nrst = 1'b0;
        @(negedge clk);
        chk(rdat, 18'h0);
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        rd(tpr_pkg::SEL_256X18, 9'h005);
        chk(rdat, E);
    endtask : t_reset

    task automatic stop_test;
        if (err_total == 0 && checks_done != 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial begin
        #1 nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        t_wide;
        t_narrow;
        t_refuse;
        t_edge;
        t_pipe;
        t_reset;
        stop_test;
    end

    // watchdog well beyond the roughly 360 cycles the tests take
    initial begin
        #100000;
        err_total++;
        stop_test;
    end
endmodule : tb_two_port_block_ram

//--- tpr_clk_edge.sv
`timescale 1ns/1ps

module tpr_clk_edge (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic port_clk_in,
    input  wire logic fall_sel_in,
    tpr_edge_if.src   edge_if
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;
    logic level_next;
    logic primed_reg;
    logic primed_next;
    logic edge_reg;
    logic edge_next;
    wire  agree;
    wire  changed;
    wire  is_active;

    // three-stage synchroniser on the port clock pin
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_reg <= tpr_pkg::BIT_RST;
            sync2_reg <= tpr_pkg::BIT_RST;
            sync3_reg <= tpr_pkg::BIT_RST;
        end else begin
            sync1_reg <= port_clk_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts once stages two and three agree
    assign agree     = (sync2_reg == sync3_reg);
    assign changed   = agree && (sync3_reg != level_reg);
    assign is_active = fall_sel_in ? !sync3_reg : sync3_reg;

    // first agreement after reset only loads the level, no event
    assign primed_next = primed_reg | agree;
    assign level_next  = (agree && (changed || !primed_reg)) ? sync3_reg : level_reg;
    assign edge_next   = changed && primed_reg && is_active;

    // accepted level and edge pulse; reset blocks all events
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_reg  <= tpr_pkg::BIT_RST;
            primed_reg <= tpr_pkg::BIT_RST;
            edge_reg   <= tpr_pkg::BIT_RST;
        end else begin
            level_reg  <= level_next;
            primed_reg <= primed_next;
            edge_reg   <= edge_next;
        end
    end

    assign edge_if.edge_pulse = edge_reg;
    assign edge_if.level      = level_reg;

endmodule : tpr_clk_edge

//--- tpr_edge_if.sv
`timescale 1ns/1ps

// carries one port clock's accepted active edge to the memory core
interface tpr_edge_if;
    logic edge_pulse;   // one core cycle per accepted active edge
    logic level;        // accepted, filtered port clock level

    modport src (output edge_pulse, output level);
    modport dst (input  edge_pulse, input  level);
endinterface : tpr_edge_if

//--- tpr_fabric_user.sv
`timescale 1ns/1ps

// fabric side of the ram: grounds the pins the chosen width leaves unused
module tpr_fabric_user (
    input  wire logic        wide_in,
    input  wire logic [8:0]  loc_in,
    input  wire logic [17:0] data_in,
    output logic      [8:0]  loc_out,
    output logic      [17:0] data_out
);
    // location top bit low when wide, upper data low when narrow
    assign loc_out  = wide_in ? {1'b0, loc_in[7:0]} : loc_in;
    assign data_out = wide_in ? data_in : {9'h000, data_in[8:0]};
endmodule : tpr_fabric_user

//--- tpr_pkg.sv
package tpr_pkg;

    // array geometry
    localparam int unsigned ADDR_W      = 9;
    localparam int unsigned DATA_W      = 18;
    localparam int unsigned HALF_W      = 9;
    localparam int unsigned DEPTH       = 512;
    localparam int unsigned SEL_W       = 2;
    localparam int unsigned WIDE_ROW_W  = 8;
    localparam int unsigned HI_LSB      = 9;
    localparam int unsigned HI_MSB      = 17;
    localparam int unsigned LO_MSB      = 8;

    // aspect-ratio codes; 00 and 11 are reserved
    localparam logic [1:0]  SEL_512X9   = 2'h1;
    localparam logic [1:0]  SEL_256X18  = 2'h2;

    // half select appended to a wide row to reach a narrow entry
    localparam logic        HALF_LO     = 1'b0;
    localparam logic        HALF_HI     = 1'b1;

    // reset values
    localparam logic [17:0] DATA_RST    = 18'h00000;
    localparam logic [8:0]  HALF_ZERO   = 9'h000;
    localparam logic        BIT_RST     = 1'b0;

endpackage : tpr_pkg

//--- tpr_two_port_ram.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Write and read ports are separate, each with its own location, data, strobe and clock.
// - A width select of 01 means 512 words of 9 bits, 10 means 256 of 18, 00 and 11 are unused.
// - Write data in and read data out are both eighteen bits wide.
// - In the 9-bit read organisation read data bits 17 to 9 carry no meaning.
// - The write location and read location are each nine bits wide.
// - Each port acts on the rising or the falling edge of its own clock, as configured.
// - Each strobe is active low by default and can be made active high.
// - While reset is low control and hold registers clear, outputs are zero, no access happens.
// - Reset never alters the stored array contents.
// - With the pipeline select low read data appears in the same read cycle as the read.
// - With the pipeline select high read data appears one read cycle later via a register.
module tpr_two_port_ram (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        WRITE_CLK_IN,
    input  wire logic        WRITE_CLK_FALL_IN,
    input  wire logic        WRITE_STROBE_IN,
    input  wire logic        WRITE_STROBE_HIGH_IN,
    input  wire logic [1:0]  WRITE_WIDTH_SEL_IN,
    input  wire logic [8:0]  WRITE_LOCATION_IN,
    input  wire logic [17:0] WRITE_DATA_IN,
    input  wire logic        READ_CLK_IN,
    input  wire logic        READ_CLK_FALL_IN,
    input  wire logic        READ_STROBE_IN,
    input  wire logic        READ_STROBE_HIGH_IN,
    input  wire logic [1:0]  READ_WIDTH_SEL_IN,
    input  wire logic [8:0]  READ_LOCATION_IN,
    input  wire logic        PIPE_IN,
    output logic      [17:0] READ_DATA_OUT,
    output logic             READ_VALID_OUT,
    output logic             WRITE_DONE_OUT,
    output logic             WIDTH_FAULT_OUT
);

    // storage: narrow entries, a wide word spans an even/odd pair
    logic [8:0]  mem [0:511];

    logic [17:0] hold_reg;
    logic [17:0] hold_next;
    logic [17:0] out_reg;
    logic [17:0] out_next;
    logic        valid_reg;
    logic        valid_next;
    logic        wdone_reg;
    logic        wdone_next;
    logic        fault_reg;
    logic        fault_next;

    wire         wr_edge;
    wire         rd_edge;
    wire         wr_strobe_act;
    wire         rd_strobe_act;
    wire         wr_narrow;
    wire         wr_wide;
    wire         rd_narrow;
    wire         rd_wide;
    wire         wr_legal;
    wire         rd_legal;
    wire         wr_go;
    wire         wr_go_hi;
    wire         rd_go;
    wire         wr_bad;
    wire         rd_bad;
    wire [8:0]   wr_idx_lo;
    wire [8:0]   wr_idx_hi;
    wire [8:0]   rd_idx_lo;
    wire [8:0]   rd_idx_hi;
    wire [8:0]   wr_half_lo;
    wire [8:0]   wr_half_hi;
    wire [8:0]   rd_half_lo;
    wire [8:0]   rd_half_hi;
    wire [17:0]  rd_word;

    // port clock edge events
    tpr_edge_if wr_edge_if ();
    tpr_edge_if rd_edge_if ();

    // write port clock, own edge select
    tpr_clk_edge u_wr_edge (
        .clk_in      (CORE_CLK_IN),
        .nrst_in     (NRST_IN),
        .port_clk_in (WRITE_CLK_IN),
        .fall_sel_in (WRITE_CLK_FALL_IN),
        .edge_if     (wr_edge_if.src)
    );

    // read port clock, own edge select
    tpr_clk_edge u_rd_edge (
        .clk_in      (CORE_CLK_IN),
        .nrst_in     (NRST_IN),
        .port_clk_in (READ_CLK_IN),
        .fall_sel_in (READ_CLK_FALL_IN),
        .edge_if     (rd_edge_if.src)
    );

    assign wr_edge = wr_edge_if.edge_pulse;
    assign rd_edge = rd_edge_if.edge_pulse;

    // strobe polarity: low active unless the high select is set
    assign wr_strobe_act = WRITE_STROBE_HIGH_IN ? WRITE_STROBE_IN : !WRITE_STROBE_IN;
    assign rd_strobe_act = READ_STROBE_HIGH_IN  ? READ_STROBE_IN  : !READ_STROBE_IN;

    // aspect-ratio decode; reserved codes refuse the access
    assign wr_narrow = (WRITE_WIDTH_SEL_IN == tpr_pkg::SEL_512X9);
    assign wr_wide   = (WRITE_WIDTH_SEL_IN == tpr_pkg::SEL_256X18);
    assign rd_narrow = (READ_WIDTH_SEL_IN  == tpr_pkg::SEL_512X9);
    assign rd_wide   = (READ_WIDTH_SEL_IN  == tpr_pkg::SEL_256X18);
    assign wr_legal  = wr_narrow | wr_wide;
    assign rd_legal  = rd_narrow | rd_wide;

    // access qualifiers; edges are held off during reset
    assign wr_go    = wr_edge && wr_strobe_act && wr_legal && NRST_IN;
    assign wr_go_hi = wr_go && wr_wide;
    assign rd_go    = rd_edge && rd_strobe_act && rd_legal && NRST_IN;
    assign wr_bad   = wr_edge && wr_strobe_act && !wr_legal;
    assign rd_bad   = rd_edge && rd_strobe_act && !rd_legal;

    // write indices: narrow uses all nine bits, wide drops bit 8
    assign wr_idx_lo = wr_narrow ? WRITE_LOCATION_IN
                     : {WRITE_LOCATION_IN[tpr_pkg::WIDE_ROW_W-1:0], tpr_pkg::HALF_LO};
    assign wr_idx_hi = {WRITE_LOCATION_IN[tpr_pkg::WIDE_ROW_W-1:0], tpr_pkg::HALF_HI};

    // write halves; upper input bits unused in narrow mode
    assign wr_half_lo = WRITE_DATA_IN[tpr_pkg::LO_MSB:0];
    assign wr_half_hi = WRITE_DATA_IN[tpr_pkg::HI_MSB:tpr_pkg::HI_LSB];

    // read indices mirror the write mapping
    assign rd_idx_lo = rd_narrow ? READ_LOCATION_IN
                     : {READ_LOCATION_IN[tpr_pkg::WIDE_ROW_W-1:0], tpr_pkg::HALF_LO};
    assign rd_idx_hi = {READ_LOCATION_IN[tpr_pkg::WIDE_ROW_W-1:0], tpr_pkg::HALF_HI};

    // read word; narrow mode drives zero on the meaningless upper bits
    assign rd_half_lo = mem[rd_idx_lo];
    assign rd_half_hi = rd_wide ? mem[rd_idx_hi] : tpr_pkg::HALF_ZERO;
    assign rd_word    = {rd_half_hi, rd_half_lo};

    // array write, no reset so contents survive it
    always_ff @(posedge CORE_CLK_IN) begin
        if (wr_go) begin
            mem[wr_idx_lo] <= wr_half_lo;
        end
        if (wr_go_hi) begin
            mem[wr_idx_hi] <= wr_half_hi;
        end
    end

    // hold register captures every granted read
    assign hold_next = rd_go ? rd_word : hold_reg;

    // output: direct on the read edge, or previous hold on the next edge
    assign out_next = PIPE_IN ? (rd_edge ? hold_reg : out_reg)
                    : (rd_go ? rd_word : out_reg);

    // pulses: fresh data on the output, write done, refused access
    assign valid_next = PIPE_IN ? (rd_edge && (hold_reg != out_reg || rd_go)) : rd_go;
    assign wdone_next = wr_go;
    assign fault_next = wr_bad || rd_bad;

    // read-side hold and output registers
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hold_reg <= tpr_pkg::DATA_RST;
            out_reg  <= tpr_pkg::DATA_RST;
        end else begin
            hold_reg <= hold_next;
            out_reg  <= out_next;
        end
    end

    // status pulses
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            valid_reg <= tpr_pkg::BIT_RST;
            wdone_reg <= tpr_pkg::BIT_RST;
            fault_reg <= tpr_pkg::BIT_RST;
        end else begin
            valid_reg <= valid_next;
            wdone_reg <= wdone_next;
            fault_reg <= fault_next;
        end
    end

    assign READ_DATA_OUT   = out_reg;
    assign READ_VALID_OUT  = valid_reg;
    assign WRITE_DONE_OUT  = wdone_reg;
    assign WIDTH_FAULT_OUT = fault_reg;

endmodule : tpr_two_port_ram

//--- tpr_two_port_ram_chk.sv
`timescale 1ns/1ps

module tpr_two_port_ram_chk (
    input wire logic        CORE_CLK_IN,
    input wire logic        NRST_IN,
    input wire logic        WRITE_CLK_IN,
    input wire logic        WRITE_CLK_FALL_IN,
    input wire logic        WRITE_STROBE_IN,
    input wire logic        WRITE_STROBE_HIGH_IN,
    input wire logic [1:0]  WRITE_WIDTH_SEL_IN,
    input wire logic        READ_CLK_IN,
    input wire logic        READ_CLK_FALL_IN,
    input wire logic        READ_STROBE_IN,
    input wire logic        READ_STROBE_HIGH_IN,
    input wire logic [1:0]  READ_WIDTH_SEL_IN,
    input wire logic        PIPE_IN,
    input wire logic [17:0] READ_DATA_OUT,
    input wire logic        READ_VALID_OUT,
    input wire logic        WRITE_DONE_OUT,
    input wire logic        WIDTH_FAULT_OUT
);
    // strobe and width qualifiers
    wire logic w_go = WRITE_STROBE_IN == WRITE_STROBE_HIGH_IN;
    wire logic r_go = READ_STROBE_IN == READ_STROBE_HIGH_IN;
    wire logic w_ok = WRITE_WIDTH_SEL_IN inside {tpr_pkg::SEL_512X9, tpr_pkg::SEL_256X18};
    wire logic r_ok = READ_WIDTH_SEL_IN inside {tpr_pkg::SEL_512X9, tpr_pkg::SEL_256X18};

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_write_edge_done: assert property ((WRITE_CLK_FALL_IN ? $fell(WRITE_CLK_IN) :
        $rose(WRITE_CLK_IN)) && w_go && w_ok |-> ##[5:6] WRITE_DONE_OUT)
        else $error("write edge gave no done pulse");
    a_write_fault: assert property ($rose(WRITE_CLK_IN) && !WRITE_CLK_FALL_IN && w_go
        && !w_ok |-> ##[5:6] WIDTH_FAULT_OUT) else $error("reserved width not flagged");
    a_done_legal: assert property (WRITE_DONE_OUT |-> w_ok)
        else $error("write done with reserved width");
    a_done_strobe: assert property (WRITE_DONE_OUT |-> w_go)
        else $error("write done with idle strobe");
    a_done_single: assert property (WRITE_DONE_OUT |=> !WRITE_DONE_OUT)
        else $error("write done longer than one cycle");
    a_read_valid: assert property (!PIPE_IN && (READ_CLK_FALL_IN ? $fell(READ_CLK_IN) :
        $rose(READ_CLK_IN)) && r_go && r_ok |-> ##[5:6] READ_VALID_OUT)
        else $error("read edge gave no valid pulse");
    a_data_then_valid: assert property (!PIPE_IN && $changed(READ_DATA_OUT)
        |-> READ_VALID_OUT) else $error("read data moved without valid");
    a_reset_quiet: assert property (disable iff (1'b0) !NRST_IN |-> READ_DATA_OUT ==
        18'h00000 && !READ_VALID_OUT && !WRITE_DONE_OUT && !WIDTH_FAULT_OUT)
        else $error("outputs active in reset");
endmodule : tpr_two_port_ram_chk

bind tpr_two_port_ram tpr_two_port_ram_chk u_chk (.*);
